// ### design/tpw_pkg.sv
// Purpose: Shared constants for the timer PWM waveform block
// Assumes: 8-bit counter, 32-bit Avalon-MM register bus
// Notes:   Offsets are byte addresses of aligned words
package tpw_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CMP_A  = 4'h4;
  localparam logic [3:0] OFS_CMP_B  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // ==========================================================
  // Control field positions
  localparam int WGM_LSB   = 0;
  localparam int CS_LSB    = 4;
  localparam int COMA_LSB  = 8;
  localparam int COMB_LSB  = 10;
  localparam int DIRA_BIT  = 12;
  localparam int DIRB_BIT  = 13;
  localparam int PORTA_BIT = 14;
  localparam int PORTB_BIT = 15;
  // ==========================================================
  // Values
  localparam logic [7:0]  BOTTOM_VAL = 8'h00;
  localparam logic [7:0]  MAX_VAL    = 8'hff;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [7:0]  CMP_RST    = 8'h00;
  localparam logic [2:0]  WGM_FAST_FF  = 3'h3;
  localparam logic [2:0]  WGM_FAST_A   = 3'h7;
  localparam logic [2:0]  WGM_PHASE_FF = 3'h1;
  localparam logic [2:0]  WGM_PHASE_A  = 3'h5;
  localparam logic [1:0]  COM_OFF    = 2'h0;
  localparam logic [1:0]  COM_TOGGLE = 2'h1;
  localparam logic [1:0]  COM_NONINV = 2'h2;
  localparam logic [1:0]  COM_INV    = 2'h3;
  // Prescale terminal counts (divide minus one)
  localparam logic [9:0] DIV8_TC    = 10'h007;
  localparam logic [9:0] DIV64_TC   = 10'h03f;
  localparam logic [9:0] DIV256_TC  = 10'h0ff;
  localparam logic [9:0] DIV1024_TC = 10'h3ff;
endpackage

// ### design/tpw_channel.sv
// Purpose: One compare channel: buffered compare value and output bit
// Assumes: Tick comes from the prescaler; direction and period edges come from the counter
// Notes:   Toggle is offered only when toggle_ok is high
`timescale 1ns/1ns
module tpw_channel
  import tpw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       fast,
  input  wire logic       phase,
  input  wire logic       toggle_ok,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] buf_value,
  input  wire logic [7:0] count,
  input  wire logic [7:0] top,
  input  wire logic       up,
  input  wire logic       load,
  input  wire logic       at_bottom,
  input  wire logic       phase_top,
  output logic      [7:0] active_value,
  output logic            bit_out
);
  logic match;
  logic inv;
  logic seen_up;

  // ==========================================================
  // Compare value transfer
  // In fast and phase modes, loading only at a period edge keeps one value per period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_value <= CMP_RST;
    end else if (!(fast || phase)) begin
      active_value <= buf_value;
    end else if (load) begin
      active_value <= buf_value;
    end
  end

  assign match = tick && (count == active_value);
  assign inv   = (mode == COM_INV);

  // Up-slope match seen since the last BOTTOM; a miss is made up there
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_up <= 1'b0;
    end else if (at_bottom) begin
      seen_up <= 1'b0;
    end else if (match && up) begin
      seen_up <= 1'b1;
    end
  end

  // ==========================================================
  // Output bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_out <= 1'b0;
    end else if (mode == COM_TOGGLE) begin
      if (toggle_ok && match) begin
        bit_out <= ~bit_out;
      end
    end else if (mode[1] && fast && tick) begin
      // Match at TOP is ignored so the level stays constant
      if (count == top) begin
        bit_out <= ~inv;
      end else if (match) begin
        bit_out <= inv;
      end
    end else if (mode[1] && phase && tick) begin
      if (phase_top && active_value == top) begin
        bit_out <= ~inv;
      end else if (match && (up || at_bottom)) begin
        // A match at BOTTOM opens the up slope, so it clears
        bit_out <= inv;
      end else if (match) begin
        bit_out <= ~inv;
      end else if (at_bottom && !seen_up && active_value != top) begin
        bit_out <= inv;
      end
    end
  end

  // Non-inverting fast mode output is set after every tick at TOP
  fast_top_a: assert property (@(posedge clk) disable iff (!rst_n)
    fast && tick && mode == COM_NONINV && count == top
      |=> bit_out) else $error("fast top not set");
endmodule

// ### design/tpw_top.sv
// Purpose: 8-bit timer waveform generator, fast and phase PWM modes
// Assumes: Avalon-MM slave, one clock, synchronous active-low reset
// Notes:   Normal and CTC modes just count up and wrap
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module tpw_top
  import tpw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             wave_pin_a,
  output logic             wave_pin_a_oe,
  output logic             wave_pin_b,
  output logic             wave_pin_b_oe
);
  // ==========================================================
  // Declarations
  logic [15:0] ctrl;
  logic [7:0]  compare_register_a;
  logic [7:0]  compare_register_b;
  logic [7:0]  count_value;
  logic        count_up;
  logic        overflow_flag;
  logic        match_flag_a;
  logic        match_flag_b;
  logic        pending;
  logic [9:0]  presc;
  logic        timer_tick;
  logic [7:0]  active_a;
  logic [7:0]  active_b;
  logic        wave_output_a;
  logic        wave_output_b;
  logic [2:0]  waveform_mode_field;
  logic [2:0]  clk_sel;
  logic [1:0]  compare_output_mode_a;
  logic [1:0]  compare_output_mode_b;
  logic        fast;
  logic        phase;
  logic [7:0]  top;
  logic        at_top;
  logic        at_bottom;
  logic        load;
  logic        phase_top;
  logic        ovf_set;
  logic        acc_wr;
  logic        acc_rd;
  logic [7:0]  next_count;

  assign waveform_mode_field   = ctrl[WGM_LSB +: 3];
  assign clk_sel               = ctrl[CS_LSB +: 3];
  assign compare_output_mode_a = ctrl[COMA_LSB +: 2];
  assign compare_output_mode_b = ctrl[COMB_LSB +: 2];

  // ==========================================================
  // Mode decode
  assign fast  = (waveform_mode_field == WGM_FAST_FF) ||
                 (waveform_mode_field == WGM_FAST_A);
  assign phase = (waveform_mode_field == WGM_PHASE_FF) ||
                 (waveform_mode_field == WGM_PHASE_A);
  // High mode bit picks compare A as top in both families
  assign top   = waveform_mode_field[2] ? active_a : MAX_VAL;
  assign at_top    = (count_value == top);
  assign at_bottom = (count_value == BOTTOM_VAL);

  // ==========================================================
  // Prescaler: free-running divider, tick is a one-cycle enable
  function automatic logic presc_hit(input logic [2:0] sel,
                                     input logic [9:0] cnt);
    case (sel)
      3'h1:    presc_hit = 1'b1;
      3'h2:    presc_hit = (cnt[2:0] == DIV8_TC[2:0]);
      3'h3:    presc_hit = (cnt[5:0] == DIV64_TC[5:0]);
      3'h4:    presc_hit = (cnt[7:0] == DIV256_TC[7:0]);
      3'h5:    presc_hit = (cnt == DIV1024_TC);
      default: presc_hit = 1'b0;  // Stopped; external sources absent
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc <= 10'h000;
    end else begin
      presc <= presc + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= presc_hit(clk_sel, presc);
    end
  end

  // ==========================================================
  // Counter
  always_comb begin
    next_count = count_value + 8'h01;
    if (fast && at_top) begin
      next_count = BOTTOM_VAL;
    end else if (phase) begin
      if (count_up && !at_top) begin
        next_count = count_value + 8'h01;
      end else if (!count_up && !at_bottom) begin
        next_count = count_value - 8'h01;
      end else if (count_up) begin
        next_count = count_value - 8'h01;
      end else begin
        next_count = count_value + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_value <= BOTTOM_VAL;
    end else if (timer_tick) begin
      count_value <= next_count;
    end
  end

  // Direction: turns down at top, up at bottom
  // Bottom wins while going down so a TOP of zero cannot lock it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_up <= 1'b1;
    end else if (!phase) begin
      count_up <= 1'b1;
    end else if (timer_tick && at_bottom && !count_up) begin
      count_up <= 1'b1;
    end else if (timer_tick && at_top) begin
      count_up <= 1'b0;
    end
  end

  // ==========================================================
  // Buffer load point and overflow event
  assign load      = timer_tick && (fast ? at_top : at_top && count_up);
  assign phase_top = at_top && count_up;
  assign ovf_set   = timer_tick &&
                     (fast  ? at_top :
                      phase ? at_bottom && !count_up :
                              count_value == MAX_VAL);

  // ==========================================================
  // Channels
  tpw_channel u_chan_a (
    .clk          (clk),
    .rst_n        (rst_n),
    .tick         (timer_tick),
    .fast         (fast),
    .phase        (phase),
    .toggle_ok    (waveform_mode_field[2]),
    .mode         (compare_output_mode_a),
    .buf_value    (compare_register_a),
    .count        (count_value),
    .top          (top),
    .up           (count_up),
    .load         (load),
    .at_bottom    (timer_tick && at_bottom),
    .phase_top    (phase_top),
    .active_value (active_a),
    .bit_out      (wave_output_a)
  );

  tpw_channel u_chan_b (
    .clk          (clk),
    .rst_n        (rst_n),
    .tick         (timer_tick),
    .fast         (fast),
    .phase        (phase),
    .toggle_ok    (1'b0),
    .mode         (compare_output_mode_b),
    .buf_value    (compare_register_b),
    .count        (count_value),
    .top          (top),
    .up           (count_up),
    .load         (load),
    .at_bottom    (timer_tick && at_bottom),
    .phase_top    (phase_top),
    .active_value (active_b),
    .bit_out      (wave_output_b)
  );

  // ==========================================================
  // Pin drive: waveform overrides port when mode is nonzero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wave_pin_a    <= 1'b0;
      wave_pin_b    <= 1'b0;
      wave_pin_a_oe <= 1'b0;
      wave_pin_b_oe <= 1'b0;
    end else begin
      wave_pin_a    <= (|compare_output_mode_a) ? wave_output_a
                       : ctrl[PORTA_BIT];
      wave_pin_b    <= (|compare_output_mode_b) ? wave_output_b
                       : ctrl[PORTB_BIT];
      wave_pin_a_oe <= ctrl[DIRA_BIT];
      wave_pin_b_oe <= ctrl[DIRB_BIT];
    end
  end

  // ==========================================================
  // Avalon slave: one wait cycle, answer on the second edge
  // Read data is captured when the request is taken so that it
  // already stands at the edge where waitrequest is seen low
  assign acc_wr = write && pending;
  assign acc_rd = read && !pending && waitrequest;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending     <= 1'b0;
      waitrequest <= 1'b1;
    end else if ((read || write) && !pending && waitrequest) begin
      pending     <= 1'b1;
      waitrequest <= 1'b0;
    end else begin
      pending     <= 1'b0;
      waitrequest <= 1'b1;
    end
  end

  // Writes to control and compare buffers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl               <= CTRL_RST;
      compare_register_a <= CMP_RST;
      compare_register_b <= CMP_RST;
    end else if (acc_wr) begin
      case (address)
        OFS_CTRL: begin
          // Bits 3 and 7 are reserved: never written, read as zero
          if (byteenable[0]) ctrl[WGM_LSB +: 3] <= writedata[WGM_LSB +: 3];
          if (byteenable[0]) ctrl[CS_LSB +: 3]  <= writedata[CS_LSB +: 3];
          if (byteenable[1]) ctrl[15:8] <= writedata[15:8];
        end
        OFS_CMP_A: begin
          if (byteenable[0]) compare_register_a <= writedata[7:0];
        end
        OFS_CMP_B: begin
          if (byteenable[0]) compare_register_b <= writedata[7:0];
        end
        default: ;
      endcase
    end
  end

  // Sticky flags: a set in the clear cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
      match_flag_a  <= 1'b0;
      match_flag_b  <= 1'b0;
    end else begin
      if (ovf_set) begin
        overflow_flag <= 1'b1;
      end else if (acc_wr && address == OFS_STATUS && writedata[0]) begin
        overflow_flag <= 1'b0;
      end
      if (timer_tick && count_value == active_a) begin
        match_flag_a <= 1'b1;
      end else if (acc_wr && address == OFS_STATUS && writedata[1]) begin
        match_flag_a <= 1'b0;
      end
      if (timer_tick && count_value == active_b) begin
        match_flag_b <= 1'b1;
      end else if (acc_wr && address == OFS_STATUS && writedata[2]) begin
        match_flag_b <= 1'b0;
      end
    end
  end

  // Read data; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (acc_rd) begin
      case (address)
        OFS_CTRL:   readdata <= {16'h0000, ctrl};
        OFS_CMP_A:  readdata <= {24'h000000, compare_register_a};
        OFS_CMP_B:  readdata <= {24'h000000, compare_register_b};
        OFS_STATUS: readdata <= {count_value, 8'h00, 8'h00,
                                 5'h00, match_flag_b, match_flag_a,
                                 overflow_flag};
        default:    readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  fast_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_tick && fast && at_top |=> count_value == BOTTOM_VAL)
    else $error("fast counter did not wrap");
  phase_turn_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_tick && phase && at_top && count_up && top != BOTTOM_VAL
    |=> !count_up) else $error("phase did not turn");
  ovf_fast_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_tick && fast && at_top |=> overflow_flag)
    else $error("overflow not set at top");
  ovf_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_tick && phase && at_bottom && !count_up |=> overflow_flag)
    else $error("overflow not set at bottom");
  tick_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_sel != 3'h1 && $past(clk_sel) != 3'h1 && timer_tick
    |=> !timer_tick)
    else $error("tick longer than one cycle");
  count_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !timer_tick |=> $stable(count_value))
    else $error("counter moved without tick");
  pin_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> wave_pin_a_oe == $past(ctrl[DIRA_BIT]))
    else $error("pin enable wrong");
  buf_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    fast && !load && $stable(fast) |=> $stable(active_b))
    else $error("compare changed mid period");

  fast_run_c:  cover property (@(posedge clk) fast && load);
  phase_run_c: cover property (@(posedge clk) phase && timer_tick &&
                               at_bottom && !count_up);
  toggle_c:    cover property (@(posedge clk)
                               compare_output_mode_a == COM_TOGGLE &&
                               $changed(wave_output_a));
endmodule

// ### verification/test_tpw_top.sv
// Purpose: Self-checking bench for the timer PWM waveform block
// Assumes: Avalon-MM master tasks, one 125 MHz clock, no partner
// Notes:   Duty is counted as pin-high cycles over whole periods,
//          so the result does not depend on where the window starts
`timescale 1ns/1ns
module test_tpw_top
  import tpw_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        wave_pin_a;
  logic        wave_pin_a_oe;
  logic        wave_pin_b;
  logic        wave_pin_b_oe;
  int          n_errors;
  int          checked;
  logic [31:0] q;

  tpw_top tpw_top_inst (
    .clk           (clk),
    .rst_n         (rst_n),
    .address       (address),
    .read          (read),
    .write         (write),
    .writedata     (writedata),
    .byteenable    (byteenable),
    .readdata      (readdata),
    .waitrequest   (waitrequest),
    .wave_pin_a    (wave_pin_a),
    .wave_pin_a_oe (wave_pin_a_oe),
    .wave_pin_b    (wave_pin_b),
    .wave_pin_b_oe (wave_pin_b_oe)
  );

  // ==========================================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Verdict and compares
  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_duty(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t duty got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Bus master: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
    int i;
    @(posedge clk);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rq = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] rq);
    bus(1'b0, a, 32'h0, rq);
  endtask

  // Control word; dp is {port B, port A, dir B, dir A}
  function automatic logic [31:0] ctrl(input logic [2:0] w,
      input logic [2:0] cs, input logic [1:0] ca, input logic [1:0] cb,
      input logic [3:0] dp);
    ctrl = 32'h0;
    ctrl[WGM_LSB +: 3]  = w;
    ctrl[CS_LSB +: 3]   = cs;
    ctrl[COMA_LSB +: 2] = ca;
    ctrl[COMB_LSB +: 2] = cb;
    ctrl[DIRA_BIT +: 4] = dp;
  endfunction

  function automatic logic [31:0] pins();
    pins = {28'h0, wave_pin_a, wave_pin_a_oe, wave_pin_b, wave_pin_b_oe};
  endfunction

  // Pin-high cycles over n clocks, sampled away from the rising edge
  task automatic duty(input int n, output logic [31:0] ha,
                      output logic [31:0] hb);
    ha = 32'h0;
    hb = 32'h0;
    repeat (n) begin
      @(negedge clk);
      if (wave_pin_a === 1'b1) ha++;
      if (wave_pin_b === 1'b1) hb++;
    end
  endtask

  // Program both channels, let buffers and any wrap settle, measure
  task automatic run_case(input logic [2:0] w, input logic [2:0] cs,
      input logic [1:0] ca, input logic [1:0] cb, input logic [7:0] oa,
      input logic [7:0] ob, input int per, input logic [31:0] ea,
      input logic [31:0] eb);
    logic [31:0] ha;
    logic [31:0] hb;
    logic [31:0] st;
    wr(OFS_CMP_A, {24'h0, oa});
    wr(OFS_CMP_B, {24'h0, ob});
    wr(OFS_CTRL, ctrl(w, cs, ca, cb, 4'h3));
    // Extra 1040 cycles cover a wrap and a turn when the old count
    // is past TOP
    repeat (2 * per + 1040) @(posedge clk);
    duty(per, ha, hb);
    chk_duty(ha, ea);
    chk_duty(hb, eb);
    rd(OFS_STATUS, st);
    chk_reg(st & 32'h1, 32'h1);
    wr(OFS_STATUS, 32'h1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    n_errors   = 0;
    checked    = 0;
    rst_n      <= 1'b0;
    address    <= 4'h0;
    read       <= 1'b0;
    write      <= 1'b0;
    writedata  <= 32'h0;
    byteenable <= 4'hf;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values of all registers and pins
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), q);
      chk_reg(q, 32'h0);
    end
    chk_reg(pins(), 32'h0);
    // Reserved bits, lane 0 compare buffer, unmapped place
    wr(OFS_CTRL, 32'hffff_ffff);
    rd(OFS_CTRL, q);
    chk_reg(q, 32'h0000_ff77);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CMP_A, 32'h1234_56a5);
    rd(OFS_CMP_A, q);
    chk_reg(q, 32'h0000_00a5);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, q);
    chk_reg(q, 32'h0);
    rd(OFS_CTRL, q);
    chk_reg(q, 32'h0);
    wr(OFS_CMP_A, 32'h0);
    // Port path, direction gate, override with counter stopped
    wr(OFS_CTRL, ctrl(3'h0, 3'h0, COM_OFF, COM_OFF, 4'h5));
    repeat (2) @(posedge clk);
    chk_reg(pins(), 32'hc);
    wr(OFS_CTRL, ctrl(3'h0, 3'h0, COM_OFF, COM_OFF, 4'h4));
    repeat (2) @(posedge clk);
    chk_reg(pins(), 32'h8);
    wr(OFS_CTRL, ctrl(3'h3, 3'h0, COM_NONINV, COM_OFF, 4'h5));
    repeat (2) @(posedge clk);
    chk_reg(pins(), 32'h4);
    wr(OFS_CTRL, ctrl(3'h0, 3'h0, COM_INV, COM_OFF, 4'h5));
    repeat (2) @(posedge clk);
    chk_reg(pins(), 32'h4);
    // Fast PWM, TOP fixed, both polarities
    run_case(3'h3, 3'h1, COM_NONINV, COM_INV, 8'h80, 8'h40, 256,
             32'h81, 32'hbf);
    run_case(3'h3, 3'h1, COM_NONINV, COM_NONINV, 8'h00, 8'hff, 256,
             32'h1, 32'h100);
    run_case(3'h3, 3'h1, COM_INV, COM_OFF, 8'hff, 8'h10, 256,
             32'h0, 32'h0);
    // Fast PWM, TOP from compare A, toggle on A
    run_case(3'h7, 3'h1, COM_TOGGLE, COM_NONINV, 8'h09, 8'h04, 20,
             32'ha, 32'ha);
    // Phase-correct PWM
    run_case(3'h1, 3'h1, COM_NONINV, COM_INV, 8'h40, 8'h20, 510,
             32'h80, 32'h1be);
    run_case(3'h1, 3'h1, COM_NONINV, COM_NONINV, 8'h00, 8'hff, 510,
             32'h0, 32'h1fe);
    run_case(3'h1, 3'h1, COM_INV, COM_INV, 8'h00, 8'hff, 510,
             32'h1fe, 32'h0);
    run_case(3'h5, 3'h1, COM_NONINV, COM_NONINV, 8'h10, 8'h08, 32,
             32'h20, 32'h10);
    // Prescaled ticks
    run_case(3'h3, 3'h2, COM_NONINV, COM_INV, 8'h7f, 8'h3f, 2048,
             32'h400, 32'h600);
    run_case(3'h3, 3'h3, COM_NONINV, COM_OFF, 8'h1f, 8'h00, 16384,
             32'h800, 32'h0);
    // Overflow flag clears on write of one with the counter stopped
    wr(OFS_CTRL, ctrl(3'h3, 3'h0, COM_NONINV, COM_OFF, 4'h3));
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, q);
    chk_reg(q & 32'h1, 32'h0);
    // Second reset in mid-run returns pins and control to zero
    wr(OFS_CTRL, ctrl(3'h3, 3'h1, COM_INV, COM_INV, 4'hf));
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_reg(pins(), 32'h0);
    rd(OFS_CTRL, q);
    chk_reg(q, 32'h0);
    tally_and_finish();
  end
endmodule
